// file: spi_port_pkg.sv
package spi_port_pkg;
  // ----------------------------------------
  // operation modes (top two bits of first byte)
  // ----------------------------------------
  localparam logic [1:0] MODE_REG_WR = 2'h0;
  localparam logic [1:0] MODE_REG_RD = 2'h1;
  localparam logic [1:0] MODE_FIFO = 2'h2;
  localparam logic [1:0] MODE_DCMD = 2'h3;
  // fifo sub codes in the six trailing bits
  localparam logic [5:0] FIFO_LOAD_CODE = 6'h00;
  localparam logic [5:0] FIFO_READ_CODE = 6'h3f;
  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int BYTE_BITS = 8;
  localparam int FIFO_DEPTH = 96;
  localparam int FIFO_PTR_W = 7;
  localparam int REG_COUNT = 64;
  // register index of operation control, bit of its enable
  localparam logic [5:0] OP_CTRL_ADDR = 6'h02;
  localparam int OP_CTRL_EN_BIT = 7;
  // highest implemented address, rest is unmapped
  localparam logic [5:0] LAST_IMPL_ADDR = 6'h3b;
  // first read-only address
  localparam logic [5:0] FIRST_RO_ADDR = 6'h30;
  // ----------------------------------------
  // link clock timing
  // ----------------------------------------
  localparam int REF_CLK_NS = 50;
  localparam int SCLK_HALF_NS = 200;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + REF_CLK_NS - 1) / REF_CLK_NS;
  localparam logic [2:0] SCLK_HALF_LOAD = 3'(SCLK_HALF_CYC - 1);
endpackage

// file: spi_link_if.sv
`timescale 1ns/100ps
interface spi_link_if;
  // chip select, active low, from master
  logic ss_n;
  // serial clock from master
  logic sclk;
  // master out
  logic mosi;
  // device out with enable
  logic miso_o;
  logic miso_oe;
  // resolved miso wire, low when nobody drives
  logic miso;
  assign miso = miso_oe ? miso_o : 1'b0;
  modport device (input ss_n, input sclk, input mosi, output miso_o, output miso_oe);
  modport master (output ss_n, output sclk, output mosi, input miso);
endinterface

// file: spi_dev_port.sv
`timescale 1ns/100ps
// Functional notes
// - serial logic reset while chip select high
// - input sampled on falling serial clock
// - bytes of eight; first byte picks mode
// - most significant bit first both ways
// - modes: write, read, fifo, direct command
// - register address increments per data byte
// - output undriven except during read data
// - fifo only when enabled and oscillator stable
// - write byte commits on its last fall
// - partial register byte discarded
// - unmapped or read-only writes ignored
// - read data changes on rising edge
// - unmapped read returns all zeros
// - fifo load, code zero, 1..96 bytes
// - partial fifo load byte not stored
// - fifo read, code ones, streams fifo
// - partly read fifo byte stays unread
// - direct command launched on last fall
// - lasting command does not block link, raises irq
// - immediate command may chain other mode
// - master keeps select high when idle
// - read: address then data bytes returned
module spi_dev_port (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // serial link
  spi_link_if.device link,
  // chip status
  input wire logic osc_stable,
  input wire logic cmd_busy,
  input wire logic cmd_done,
  // fifo fill from the receiver side
  input wire logic rx_push,
  input wire logic [7:0] rx_byte,
  // fifo drain toward the transmitter
  input wire logic tx_pop,
  output logic [7:0] tx_byte,
  output logic fifo_empty,
  // direct command launch
  output logic cmd_strobe,
  output logic [5:0] cmd_code_bits,
  output logic irq
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] ss_sync_r, sclk_sync_r, mosi_sync_r;
  logic ss_q_r, sclk_q_r;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ss_sync_r <= 2'h3;
      sclk_sync_r <= 2'h0;
      mosi_sync_r <= 2'h0;
      ss_q_r <= 1'b1;
      sclk_q_r <= 1'b0;
    end else begin
      ss_sync_r <= {ss_sync_r[0], link.ss_n};
      sclk_sync_r <= {sclk_sync_r[0], link.sclk};
      mosi_sync_r <= {mosi_sync_r[0], link.mosi};
      ss_q_r <= ss_sync_r[1];
      sclk_q_r <= sclk_sync_r[1];
    end
  end
  logic ss_hi, sclk_fall, sclk_rise, mosi_s;
  assign ss_hi = ss_sync_r[1];
  assign sclk_fall = sclk_q_r & ~sclk_sync_r[1];
  assign sclk_rise = ~sclk_q_r & sclk_sync_r[1];
  assign mosi_s = mosi_sync_r[1];

  // ----------------------------------------
  // register file and fifo storage
  // ----------------------------------------
  logic [7:0] regs_r [spi_port_pkg::REG_COUNT];
  logic [7:0] fifo_r [spi_port_pkg::FIFO_DEPTH];
  logic [6:0] wr_ptr_r, rd_ptr_r, count_r;

  typedef enum {ST_HEAD, ST_REG_WR, ST_REG_RD, ST_FIFO_LD, ST_FIFO_RD, ST_IGNORE} port_state_e;
  port_state_e state_r, state_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [5:0] addr_r, addr_nxt;
  logic [7:0] out_r, out_nxt;
  logic oe_r, oe_nxt;
  logic cmd_r, cmd_nxt;
  logic [5:0] code_r, code_nxt;
  logic reg_we, fifo_we, fifo_pop_spi;
  logic [7:0] byte_in;
  logic fifo_ok;

  assign byte_in = {sh_r[6:0], mosi_s};
  assign fifo_ok = regs_r[spi_port_pkg::OP_CTRL_ADDR][spi_port_pkg::OP_CTRL_EN_BIT] & osc_stable;

  // read value for an address, zero when unmapped
  function automatic logic [7:0] reg_rd(input logic [5:0] a);
    reg_rd = (a > spi_port_pkg::LAST_IMPL_ADDR) ? 8'h00 : regs_r[a];
  endfunction

  // ----------------------------------------
  // serial state machine, next values
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    addr_nxt = addr_r;
    out_nxt = out_r;
    oe_nxt = oe_r;
    cmd_nxt = 1'b0;
    code_nxt = code_r;
    reg_we = 1'b0;
    fifo_we = 1'b0;
    fifo_pop_spi = 1'b0;
    // held in reset while select high
    if (ss_hi) begin
      state_nxt = ST_HEAD;
      bit_nxt = 3'h0;
      sh_nxt = 8'h00;
      oe_nxt = 1'b0;
    end else if (sclk_fall) begin
      sh_nxt = byte_in;
      bit_nxt = bit_r + 3'h1;
      if (bit_r == 3'h7) begin
        case (state_r)
          ST_HEAD: begin
            addr_nxt = byte_in[5:0];
            case (byte_in[7:6])
              spi_port_pkg::MODE_REG_WR: state_nxt = ST_REG_WR;
              spi_port_pkg::MODE_REG_RD: state_nxt = ST_REG_RD;
              spi_port_pkg::MODE_FIFO: begin
                if (!fifo_ok) state_nxt = ST_IGNORE;
                else if (byte_in[5:0] == spi_port_pkg::FIFO_LOAD_CODE) state_nxt = ST_FIFO_LD;
                else if (byte_in[5:0] == spi_port_pkg::FIFO_READ_CODE) state_nxt = ST_FIFO_RD;
                else state_nxt = ST_IGNORE;
              end
              default: begin
                cmd_nxt = 1'b1;
                code_nxt = byte_in[5:0];
                state_nxt = ST_HEAD;
              end
            endcase
          end
          ST_REG_WR: begin
            reg_we = 1'b1;
            addr_nxt = addr_r + 6'h1;
          end
          ST_REG_RD: addr_nxt = addr_r + 6'h1;
          // only whole bytes enter the fifo
          ST_FIFO_LD: fifo_we = (count_r != 7'(spi_port_pkg::FIFO_DEPTH));
          // pop only after a full byte went out
          ST_FIFO_RD: fifo_pop_spi = (count_r != 7'h00);
          default: state_nxt = state_r;
        endcase
      end
    end else if (sclk_rise) begin
      case (state_r)
        ST_REG_RD: begin
          oe_nxt = 1'b1;
          out_nxt = reg_rd(addr_r) << bit_r;
        end
        ST_FIFO_RD: begin
          oe_nxt = 1'b1;
          out_nxt = ((count_r == 7'h00) ? 8'h00 : fifo_r[rd_ptr_r]) << bit_r;
        end
        default: oe_nxt = 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // serial state registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_r <= ST_HEAD;
      bit_r <= 3'h0;
      sh_r <= 8'h00;
      addr_r <= 6'h00;
      out_r <= 8'h00;
      oe_r <= 1'b0;
      cmd_r <= 1'b0;
      code_r <= 6'h00;
    end else begin
      state_r <= state_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      addr_r <= addr_nxt;
      out_r <= out_nxt;
      oe_r <= oe_nxt;
      cmd_r <= cmd_nxt;
      code_r <= code_nxt;
    end
  end
  assign link.miso_o = out_r[7];
  assign link.miso_oe = oe_r;
  assign cmd_strobe = cmd_r;
  assign cmd_code_bits = code_r;

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  // partial bytes never reach reg_we, so a short frame changes nothing
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      for (int i = 0; i < spi_port_pkg::REG_COUNT; i++) regs_r[i] <= 8'h00;
    end else if (reg_we && addr_r < spi_port_pkg::FIRST_RO_ADDR) begin
      regs_r[addr_r] <= byte_in;
    end
  end

  // ----------------------------------------
  // fifo pointers, next values
  // ----------------------------------------
  logic do_push, do_pop;
  logic [7:0] push_data;
  logic [6:0] wr_ptr_nxt, rd_ptr_nxt, count_nxt;
  logic [7:0] tx_byte_nxt;
  logic irq_nxt, empty_nxt;
  always_comb begin
    // spi side wins over the chip side when both want the fifo
    do_push = fifo_we | (rx_push & (count_r != 7'(spi_port_pkg::FIFO_DEPTH)));
    push_data = fifo_we ? byte_in : rx_byte;
    do_pop = fifo_pop_spi | (tx_pop & (count_r != 7'h00) & ~fifo_pop_spi);
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    count_nxt = count_r;
    if (do_push) wr_ptr_nxt = (wr_ptr_r == 7'(spi_port_pkg::FIFO_DEPTH - 1)) ? 7'h00 : wr_ptr_r + 7'h1;
    if (do_pop) rd_ptr_nxt = (rd_ptr_r == 7'(spi_port_pkg::FIFO_DEPTH - 1)) ? 7'h00 : rd_ptr_r + 7'h1;
    if (do_push && !do_pop) count_nxt = count_r + 7'h1;
    else if (do_pop && !do_push) count_nxt = count_r - 7'h1;
    tx_byte_nxt = fifo_r[rd_ptr_nxt];
    empty_nxt = (count_nxt == 7'h00);
    // irq on lasting command completion, held until next command
    irq_nxt = cmd_done ? 1'b1 : (cmd_r ? 1'b0 : irq);
  end

  // ----------------------------------------
  // fifo and status registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      wr_ptr_r <= 7'h00;
      rd_ptr_r <= 7'h00;
      count_r <= 7'h00;
      tx_byte <= 8'h00;
      fifo_empty <= 1'b1;
      irq <= 1'b0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r <= count_nxt;
      tx_byte <= tx_byte_nxt;
      fifo_empty <= empty_nxt;
      irq <= irq_nxt;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (do_push) fifo_r[wr_ptr_r] <= push_data;
  end
  // cmd_busy is left unused; master must wait per protocol
  logic unused_busy;
  assign unused_busy = cmd_busy;
endmodule

// file: spi_host_port.sv
`timescale 1ns/100ps
module spi_host_port (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // serial link
  spi_link_if.master link,
  // user request: header byte, count of data bytes after it
  input wire logic req_valid,
  input wire logic [7:0] req_head,
  input wire logic [6:0] req_len,
  output logic req_ready,
  // write data, taken when wr_take pulses
  input wire logic [7:0] wr_data,
  output logic wr_take,
  // read data out
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic done
);
  // ----------------------------------------
  // miso synchroniser
  // ----------------------------------------
  logic [1:0] miso_sync_r;
  always_ff @(posedge ref_clk) begin
    if (!rstn) miso_sync_r <= 2'h0;
    else miso_sync_r <= {miso_sync_r[0], link.miso};
  end

  typedef enum {H_IDLE, H_LEAD, H_HIGH, H_LOW, H_TAIL} host_state_e;
  host_state_e st_r, st_nxt;
  logic [2:0] div_r, div_nxt, bit_r, bit_nxt;
  logic [6:0] left_r, left_nxt;
  logic [7:0] tx_r, tx_nxt, rx_r, rx_nxt, rd_r, rd_nxt;
  logic ss_r, ss_nxt, sclk_r, sclk_nxt, mosi_r, mosi_nxt;
  logic rdy_r, rdy_nxt, take_r, take_nxt, rv_r, rv_nxt, done_r, done_nxt;

  // ----------------------------------------
  // byte engine, next values
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    div_nxt = (div_r == 3'h0) ? spi_port_pkg::SCLK_HALF_LOAD : div_r - 3'h1;
    bit_nxt = bit_r;
    left_nxt = left_r;
    tx_nxt = tx_r;
    rx_nxt = rx_r;
    rd_nxt = rd_r;
    ss_nxt = ss_r;
    sclk_nxt = sclk_r;
    mosi_nxt = mosi_r;
    rdy_nxt = 1'b0;
    take_nxt = 1'b0;
    rv_nxt = 1'b0;
    done_nxt = 1'b0;
    case (st_r)
      H_IDLE: begin
        ss_nxt = 1'b1;
        sclk_nxt = 1'b0;
        // ready only once select has stood high for a full half period
        rdy_nxt = rdy_r | (div_r == 3'h0);
        if (req_valid && rdy_r) begin
          rdy_nxt = 1'b0;
          ss_nxt = 1'b0;
          tx_nxt = req_head;
          left_nxt = req_len;
          bit_nxt = 3'h0;
          div_nxt = spi_port_pkg::SCLK_HALF_LOAD;
          st_nxt = H_LEAD;
        end
      end
      H_LEAD: if (div_r == 3'h0) begin
        mosi_nxt = tx_r[7];
        sclk_nxt = 1'b1;
        st_nxt = H_HIGH;
      end
      H_HIGH: if (div_r == 3'h0) begin
        sclk_nxt = 1'b0;
        tx_nxt = {tx_r[6:0], 1'b0};
        st_nxt = H_LOW;
        if (bit_r == 3'h7) begin
          if (left_r == 7'h00) begin
            st_nxt = H_TAIL;
          end else begin
            left_nxt = left_r - 7'h1;
            tx_nxt = wr_data;
            take_nxt = 1'b1;
          end
        end
        bit_nxt = bit_r + 3'h1;
      end
      H_LOW: if (div_r == 3'h0) begin
        mosi_nxt = tx_r[7];
        sclk_nxt = 1'b1;
        st_nxt = H_HIGH;
      end
      H_TAIL: if (div_r == 3'h0) begin
        // clock rests low before select rises
        ss_nxt = 1'b1;
        done_nxt = 1'b1;
        st_nxt = H_IDLE;
      end
      default: st_nxt = H_IDLE;
    endcase
    // take the returned bit two cycles into the low phase
    // the device answers a few cycles after the rise and miso then crosses
    // two sync stages, so the bit is not yet visible at the fall itself
    if ((st_r == H_LOW || st_r == H_TAIL) && div_r == 3'h2) begin
      rx_nxt = {rx_r[6:0], miso_sync_r[1]};
      // a whole byte has come back
      if (bit_r == 3'h0) begin
        rd_nxt = {rx_r[6:0], miso_sync_r[1]};
        rv_nxt = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // byte engine registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st_r <= H_IDLE;
      div_r <= 3'h0;
      bit_r <= 3'h0;
      left_r <= 7'h00;
      tx_r <= 8'h00;
      rx_r <= 8'h00;
      rd_r <= 8'h00;
      ss_r <= 1'b1;
      sclk_r <= 1'b0;
      mosi_r <= 1'b0;
      rdy_r <= 1'b0;
      take_r <= 1'b0;
      rv_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      div_r <= div_nxt;
      bit_r <= bit_nxt;
      left_r <= left_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
      rd_r <= rd_nxt;
      ss_r <= ss_nxt;
      sclk_r <= sclk_nxt;
      mosi_r <= mosi_nxt;
      rdy_r <= rdy_nxt;
      take_r <= take_nxt;
      rv_r <= rv_nxt;
      done_r <= done_nxt;
    end
  end
  assign link.ss_n = ss_r;
  assign link.sclk = sclk_r;
  assign link.mosi = mosi_r;
  assign req_ready = rdy_r;
  assign wr_take = take_r;
  assign rd_data = rd_r;
  assign rd_valid = rv_r;
  assign done = done_r;
endmodule

// file: spi_port_chk.sv
`timescale 1ns/100ps
module spi_port_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // link wires seen between the two ends
  input wire logic ss_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic miso
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // helper: serial clock falls counted per frame
  // ----------------------------------------
  logic sclk_r; // serial clock one cycle back
  logic [2:0] bit_cnt_r, bit_cnt_nxt; // bits seen modulo eight
  // next count, cleared while deselected
  always_comb begin
    bit_cnt_nxt = bit_cnt_r;
    if (!rstn || ss_n) begin
      bit_cnt_nxt = 3'h0;
    end else if (sclk_r && !sclk) begin
      bit_cnt_nxt = bit_cnt_r + 3'h1;
    end
  end
  // register only
  always_ff @(posedge ref_clk) begin
    sclk_r <= sclk;
    bit_cnt_r <= bit_cnt_nxt;
  end
  // ----------------------------------------
  // sequences and assertions
  // ----------------------------------------
  sequence quiet_clk;
    !sclk [*3];
  endsequence
  sequence idle_gap;
    ss_n [*4];
  endsequence
  sequence held_sel;
    !ss_n [*8];
  endsequence
  sclk_idle_a: assert property (ss_n |-> !sclk)
    else $error("serial clock high while deselected");
  cs_setup_a: assert property ($fell(ss_n) |-> quiet_clk)
    else $error("serial clock rose too soon after select");
  byte_frame_a: assert property ($rose(ss_n) |-> bit_cnt_r == 3'h0)
    else $error("frame ended off a byte boundary");
  mosi_hold_a: assert property ($fell(sclk) && !ss_n |-> $stable(mosi))
    else $error("master data moved at sampling edge");
  oe_idle_a: assert property (ss_n [*6] |-> !miso_oe && !miso)
    else $error("device drives while deselected");
  oe_rise_a: assert property ($rose(miso_oe) |-> held_sel)
    else $error("device output enabled outside a read");
  miso_edge_a: assert property (miso_oe && $past(miso_oe) && $changed(miso_o) |-> sclk)
    else $error("read data changed while clock low");
  frame_gap_a: assert property ($rose(ss_n) |-> idle_gap)
    else $error("frames too close");
endmodule

// file: reader_spi_slave_host_port_tb_top.sv
`timescale 1ns/100ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_mismatch++; $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module reader_spi_slave_host_port_tb_top;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic ref_clk, rstn, osc_stable, cmd_done, rx_push, tx_pop, req_valid, req_ready, wr_take, rd_valid, done;
  logic [7:0] rx_byte, tx_byte, req_head, wr_data, rd_data, cap;
  logic [6:0] req_len;
  logic fifo_empty, cmd_strobe, irq;
  logic [5:0] cmd_code_bits;
  int total_checks, n_mismatch, n_cmd;
  logic [7:0] wq[$], rq[$]; // bytes to send, bytes read back
  typedef struct {logic [5:0] addr; logic [7:0] wdat; logic [7:0] exp;} row_s;
  // plain write then read back; read-only and unmapped give zero
  row_s rows [5] = '{'{6'h05, 8'haa, 8'haa}, '{6'h2f, 8'h5c, 8'h5c}, '{6'h30, 8'h77, 8'h00},
    '{6'h3c, 8'h12, 8'h00}, '{6'h3f, 8'hff, 8'h00}};
  spi_link_if l0 ();
  spi_link_if l1 (); // second link, driven by the bench to cut bytes short
  // ----------------------------------------
  // the two ends, plus a device on the bench link
  // ----------------------------------------
  spi_host_port u_spi_host_port (.ref_clk(ref_clk), .rstn(rstn), .link(l0), .req_valid(req_valid),
    .req_head(req_head), .req_len(req_len), .req_ready(req_ready), .wr_data(wr_data), .wr_take(wr_take),
    .rd_data(rd_data), .rd_valid(rd_valid), .done(done));
  spi_dev_port u_spi_dev_port (.ref_clk(ref_clk), .rstn(rstn), .link(l0), .osc_stable(osc_stable),
    .cmd_busy(1'b0), .cmd_done(cmd_done), .rx_push(rx_push), .rx_byte(rx_byte), .tx_pop(tx_pop),
    .tx_byte(tx_byte), .fifo_empty(fifo_empty), .cmd_strobe(cmd_strobe), .cmd_code_bits(cmd_code_bits),
    .irq(irq));
  spi_dev_port u_spi_dev_port_b (.ref_clk(ref_clk), .rstn(rstn), .link(l1), .osc_stable(osc_stable),
    .cmd_busy(1'b0), .cmd_done(cmd_done), .rx_push(1'b0), .rx_byte(8'h00), .tx_pop(1'b0), .tx_byte(),
    .fifo_empty(), .cmd_strobe(), .cmd_code_bits(), .irq());
  spi_port_chk u_spi_port_chk (.ref_clk(ref_clk), .rstn(rstn), .ss_n(l0.ss_n), .sclk(l0.sclk),
    .mosi(l0.mosi), .miso_o(l0.miso_o), .miso_oe(l0.miso_oe), .miso(l0.miso));
  // 20 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // count launched commands
  always @(posedge ref_clk) begin
    if (cmd_strobe === 1'b1) n_cmd++;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // one host frame: header h then n bytes; wr_data moves on after each take
  task automatic run(input logic [7:0] h, input logic [6:0] n);
    int i, k;
    i = 0;
    k = 0;
    rq = {};
    wr_data = (wq.size() > 0) ? wq[0] : 8'h00;
    step(1);
    req_valid = 1'b1;
    req_head = h;
    req_len = n;
    do @(posedge ref_clk); while (req_ready !== 1'b1 && ++k < 50);
    #1 req_valid = 1'b0;
    // a request never taken counts as a mismatch
    if (k >= 50) n_mismatch++;
    forever begin
      @(posedge ref_clk);
      if (rd_valid === 1'b1) rq.push_back(rd_data);
      if (done === 1'b1) break;
      if (++k > 20000) begin
        n_mismatch++;
        break;
      end
      if (wr_take === 1'b1) begin
        i++;
        #1 wr_data = (i < wq.size()) ? wq[i] : 8'h00;
      end
    end
    #1;
    // the byte returned under the header is never driven by the device
    `CHK(rq[0], 8'h00)
    rq.delete(0);
  endtask
  // bench link: n bits msb first, 400 ns period, capture on each fall
  task automatic bits(input logic [7:0] v, input int n);
    for (int j = 0; j < n; j++) begin
      step(1);
      l1.sclk = 1'b1;
      step(2);
      l1.mosi = v[7-j];
      step(2);
      l1.sclk = 1'b0;
      cap = {cap[6:0], l1.miso};
      repeat (3) @(posedge ref_clk);
    end
  endtask
  task automatic sel(input logic s);
    step(8);
    l1.ss_n = s;
  endtask
  // header byte then n bits of a second byte, in one frame
  task automatic fr(input logic [7:0] a, input logic [7:0] b, input int n);
    sel(1'b0);
    bits(a, 8);
    bits(b, n);
    sel(1'b1);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // watchdog, well past the expected run
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_mismatch++;
    report_and_stop;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rstn, cmd_done, rx_push, tx_pop, req_valid, req_head, req_len, wr_data, rx_byte} = '0;
    {l1.sclk, l1.mosi, n_cmd, total_checks, n_mismatch} = '0;
    osc_stable = 1'b1;
    l1.ss_n = 1'b1;
    repeat (12) @(posedge ref_clk);
    #1 rstn = 1'b1;
    step(2);
    `CHK({l0.ss_n, l0.sclk, l0.miso_oe, irq, fifo_empty}, 5'h11)
    foreach (rows[r]) begin
      wq = {rows[r].wdat};
      run({spi_port_pkg::MODE_REG_WR, rows[r].addr}, 7'h01);
      run({spi_port_pkg::MODE_REG_RD, rows[r].addr}, 7'h01);
      `CHK(rq[0], rows[r].exp)
    end
    // burst write and read with address increment
    wq = {8'h11, 8'h22, 8'h33};
    run(8'h10, 7'h03);
    run(8'h50, 7'h03);
    for (int j = 0; j < 3; j++) `CHK(rq[j], wq[j])
    // bench link: full, then cut write byte
    fr(8'h07, 8'h99, 8);
    fr(8'h07, 8'h66, 5);
    fr(8'h47, 8'h00, 8);
    `CHK(cap, 8'h99)
    // enable fifo, load two bytes and a cut one, read one, a cut one, the kept one, then one from empty
    fr(8'h02, 8'h80, 8);
    sel(1'b0);
    bits(8'h80, 8);
    bits(8'he1, 8);
    bits(8'hd4, 8);
    bits(8'hf2, 4);
    sel(1'b1);
    fr(8'hbf, 8'h00, 8);
    `CHK(cap, 8'he1)
    fr(8'hbf, 8'h00, 3);
    fr(8'hbf, 8'h00, 8);
    `CHK(cap, 8'hd4)
    fr(8'hbf, 8'h00, 8);
    `CHK(cap, 8'h00)
    // fifo refused while disabled
    wq = {8'h01, 8'h02};
    run(8'h80, 7'h02);
    `CHK(fifo_empty, 1'b1)
    wq = {8'h80};
    run(8'h02, 7'h01);
    wq = {8'ha1, 8'hb2, 8'hc3};
    run(8'h80, 7'h03);
    `CHK(tx_byte, 8'ha1)
    run(8'hbf, 7'h02);
    `CHK({rq[0], rq[1]}, 16'ha1b2)
    osc_stable = 1'b0;
    run(8'hbf, 7'h01);
    `CHK({rq[0], tx_byte}, 16'h00c3)
    osc_stable = 1'b1;
    tx_pop = 1'b1;
    step(1);
    {tx_pop, rx_push, rx_byte} = 10'h15e;
    step(1);
    rx_push = 1'b0;
    step(2);
    run(8'hbf, 7'h01);
    `CHK(rq[0], 8'h5e)
    // direct command, completion flag, chained write
    run(8'hd5, 7'h00);
    `CHK({n_cmd[1:0], cmd_code_bits}, 8'h55)
    cmd_done = 1'b1;
    step(1);
    cmd_done = 1'b0;
    step(2);
    `CHK(irq, 1'b1)
    wq = {8'h05, 8'h3c};
    run(8'hc7, 7'h02);
    `CHK({n_cmd[1:0], cmd_code_bits, irq}, 9'h10e)
    run(8'h45, 7'h01);
    `CHK(rq[0], 8'h3c)
    report_and_stop;
  end
endmodule
